// File: logic/mps_pkg.sv
/*
 * Package for the multiphase PWM sequencer: timing constants, widths,
 * mode and state enumerations and the packed carriers of the design.
 * Assumes a single 20 MHz clock domain.
 */
`default_nettype none
package mps_pkg;
    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000; // System clock rate
    localparam int unsigned POR_DELAY_US = 2600; // 2.6 ms from POR crossing
    // Least time, rounded up to whole cycles
    localparam int unsigned POR_DELAY_CYC =
        (POR_DELAY_US * (CLK_HZ / 1_000_000) + 0) ;
    localparam int unsigned SS_STEP_CYC = 20;    // Cycles per soft-start step
    localparam int unsigned CNT_W = 16;          // Width of the delay counter
    localparam int unsigned DAC_W = 8;           // Target DAC code width
    localparam int unsigned NPH = 3;             // Primary rail slices
    localparam logic [DAC_W-1:0] DAC_RST = 8'h00; // DAC start value
    localparam logic [1:0] SLOT_FIRST = 2'h0;    // Rotation start slot

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Primary rail phase count
    typedef enum logic [1:0] {
        MPS_PH1 = 2'h1,
        MPS_PH2 = 2'h2,
        MPS_PH3 = 2'h3
    } mps_phases_e;

    // Start-up sequencer states
    typedef enum logic [1:0] {
        ST_OFF,
        ST_WAIT,
        ST_RAMP,
        ST_RUN
    } mps_state_e;

    // Comparator events from one rail (pulses)
    typedef struct packed {
        logic [NPH-1:0] window_hit;  // Slave ramp reached window threshold
        logic [NPH-1:0] zero_cross;  // Phase node reached zero
        logic master_hit;            // Master ramp reached error-amp level
    } mps_cmp_s;

    // Gate-side outputs of one rail
    typedef struct packed {
        logic [NPH-1:0] pwm;            // PWM outputs
        logic [NPH-1:0] low_side_gate;  // Low-side gate enables
        logic [NPH-1:0] phase_clock;    // Phase clock pulses
    } mps_gate_s;
endpackage
`default_nettype wire

// File: logic/mps_sequencer.sv
/*
 * Multiphase PWM sequencer top: master clock one-shot, round-robin phase
 * distribution, per-slice PWM latches, reverse-current block on the
 * low-side gates and the start-up sequencer for both rails.
 * Assumes comparator inputs are synchronous single-cycle pulses or levels
 * and that the analog modulator restarts its ramp on ramp_reset_o.
 */
// Notes on behaviour
// - Primary rail one to three phases, secondary single
// - Master comparator event gives one pulse, ramp restart
// - Three-phase mode rotates pulses over phases 1,2,3
// - Two-phase mode alternates pulses between phases 1,2
// - Single-phase mode routes every pulse to phase 1
// - Phase clock pulse sets slice PWM high
// - Window comparator event drives slice PWM low
// - Block mode turns low gate off at zero
// - Start needs POR good and regulator request high
// - Soft-start steps DAC toward latest target command
// - Ramp done: power good high, attention low
// - Request high at POR: start after 2.6 ms
`timescale 1ns/10ps
`default_nettype none
module mps_sequencer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Supply and host control
    input wire logic por_ok_i,
    input wire logic regulator_on_request_i,
    input wire logic reverse_current_block_mode_i,
    input wire mps_pkg::mps_phases_e phases_i,
    // Target voltage command
    input wire logic set_target_voltage_cmd_i,
    input wire logic [mps_pkg::DAC_W-1:0] target_code_i,
    // Comparators, primary and secondary rail
    input wire mps_pkg::mps_cmp_s pri_cmp_i,
    input wire mps_pkg::mps_cmp_s sec_cmp_i,
    // Gate outputs
    output mps_pkg::mps_gate_s pri_gate_o,
    output mps_pkg::mps_gate_s sec_gate_o,
    output logic [1:0] ramp_reset_o,
    // Status outputs
    output logic [mps_pkg::DAC_W-1:0] dac_code_o,
    output logic power_good_out_o,
    output logic alert_n_o
);
    import mps_pkg::*;
    // One clock domain; comparator inputs are taken as clean synchronous
    // pulses, so no input stage sits in front of the logic

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_q; // Release shifter
    logic rst_n;            // Synchronised reset
    // Asserts at once, releases after two edges
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    // Only the second stage is read, so a release close to an edge never
    // reaches the logic as a half-settled level
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------------
    mps_state_e state_q;               // Sequencer state
    logic [CNT_W-1:0] cnt_q;           // Delay / step counter
    logic [DAC_W-1:0] target_q;        // Latest commanded target
    logic [DAC_W-1:0] dac_q;           // Ramping DAC value
    logic por_q;                       // POR level one cycle ago
    logic active;                      // Switching allowed
    // Counters load one less than the span, since the cycle at zero is
    // the last cycle of that span
    localparam logic [CNT_W-1:0] POR_CNT = CNT_W'(POR_DELAY_CYC - 1);
    localparam logic [CNT_W-1:0] STEP_CNT = CNT_W'(SS_STEP_CYC - 1);

    // Remember the most recent target command
    // A command during the ramp retargets it; one in run applies at once
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            target_q <= DAC_RST;
        end else if (set_target_voltage_cmd_i) begin
            target_q <= target_code_i;
        end
    end

    // Track POR for rising-crossing detection
    // Resets low: a supply already good when reset lifts with the request
    // high counts as a crossing and waits out the full delay, the safe side
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            por_q <= 1'b0;
        end else begin
            por_q <= por_ok_i;
        end
    end

    // Sequencer state, counter and DAC ramp
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_OFF;
            cnt_q <= '0;
            dac_q <= DAC_RST;
        end else if (!por_ok_i || !regulator_on_request_i) begin
            // Losing supply or request drops back to idle
            state_q <= ST_OFF;
            cnt_q <= '0;
            dac_q <= DAC_RST;
        end else begin
            unique case (state_q)
                ST_OFF: begin
                    if (!por_q) begin
                        // Request already high at POR crossing
                        state_q <= ST_WAIT;
                        cnt_q <= POR_CNT;
                    end else begin
                        // Supply good for a while: start stepping now
                        state_q <= ST_RAMP;
                        cnt_q <= STEP_CNT;
                    end
                end
                ST_WAIT: begin
                    // Hold off switching for the power-on delay
                    if (cnt_q == '0) begin
                        state_q <= ST_RAMP;
                        cnt_q <= STEP_CNT;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_RAMP: begin
                    // One code per step toward the target
                    if (dac_q == target_q) begin
                        state_q <= ST_RUN;
                    end else if (cnt_q == '0) begin
                        cnt_q <= STEP_CNT;
                        dac_q <= (dac_q < target_q) ? dac_q + 1'b1
                                                    : dac_q - 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_RUN: begin
                    // Later commands are applied directly
                    // Stepping is for start-up only, not for run changes
                    dac_q <= target_q;
                end
            endcase
        end
    end
    // Switching is allowed from the first ramp step on
    assign active = (state_q == ST_RAMP) || (state_q == ST_RUN);

    // Status outputs, registered
    // Both pins come from one state, so they move on the same edge
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            power_good_out_o <= 1'b0;
            alert_n_o <= 1'b1;
            dac_code_o <= DAC_RST;
        end else begin
            power_good_out_o <= (state_q == ST_RUN);
            alert_n_o <= !(state_q == ST_RUN);
            dac_code_o <= dac_q;
        end
    end

    // ------------------------------------------------------------------
    // Phase rotation
    // ------------------------------------------------------------------
    // Next slot in the rotation for a given phase count
    // A count of zero wraps only at slot 3, where no slice listens, and
    // enables no slice at all, so all pulses are lost; zero must not be used
    function automatic logic [1:0] next_slot(input logic [1:0] s,
                                             input mps_phases_e p);
        logic [1:0] last;
        last = 2'(p) - 2'h1;
        next_slot = (s >= last) ? SLOT_FIRST : s + 2'h1;
    endfunction

    logic [1:0] slot_q;           // Primary slot to receive the next pulse
    logic [NPH-1:0] pri_clk;      // Primary phase clocks this cycle
    logic [NPH-1:0] sec_clk;      // Secondary phase clock this cycle

    // Advance on every master pulse; reset to phase 1 while idle
    // Lowering the count while running can send one pulse to a slice
    // that is off; change the count only while idle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            slot_q <= SLOT_FIRST;
        end else if (!active) begin
            slot_q <= SLOT_FIRST;
        end else if (pri_cmp_i.master_hit) begin
            slot_q <= next_slot(slot_q, phases_i);
        end
    end

    // Decode the slot into a one-hot phase clock
    // Only one bit is ever set, so phases can never overlap their clocks
    always_comb begin
        pri_clk = '0;
        sec_clk = '0;
        if (active && pri_cmp_i.master_hit) begin
            pri_clk[slot_q] = 1'b1;
        end
        if (active && sec_cmp_i.master_hit) begin
            sec_clk[0] = 1'b1;
        end
    end

    // One-shot master pulse restarts each rail's ramp
    // Registered like the phase clocks, so the ramp restart and the
    // phase clock leave on the same edge
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ramp_reset_o <= 2'h0;
        end else begin
            ramp_reset_o <= {active & sec_cmp_i.master_hit,
                             active & pri_cmp_i.master_hit};
        end
    end

    // ------------------------------------------------------------------
    // Phase slices
    // ------------------------------------------------------------------
    // Slices above the phase count and unused secondary slices stay off
    logic [NPH-1:0] pri_en; // Primary slice in use
    logic [NPH-1:0] sec_en; // Secondary slice in use
    // The secondary rail is single phase by construction
    assign sec_en = 3'h1;

    // One slice per bit; the secondary rail reuses the same loop with
    // only its first slice enabled
    genvar g;
    generate
        for (g = 0; g < NPH; g++) begin : g_slice
            assign pri_en[g] = (g < int'(phases_i));

            // Primary slice: set on clock, clear on window hit
            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    pri_gate_o.pwm[g] <= 1'b0;
                    pri_gate_o.low_side_gate[g] <= 1'b0;
                    pri_gate_o.phase_clock[g] <= 1'b0;
                end else if (!active || !pri_en[g]) begin
                    pri_gate_o.pwm[g] <= 1'b0;
                    pri_gate_o.low_side_gate[g] <= 1'b0;
                    pri_gate_o.phase_clock[g] <= 1'b0;
                end else begin
                    pri_gate_o.phase_clock[g] <= pri_clk[g];
                    // A clock beats a window hit in the same cycle, so a
                    // new period is never cut short at its start
                    if (pri_clk[g]) begin
                        pri_gate_o.pwm[g] <= 1'b1;
                        pri_gate_o.low_side_gate[g] <= 1'b0;
                    end else if (pri_cmp_i.window_hit[g]) begin
                        // End of on-time: the low side takes over
                        pri_gate_o.pwm[g] <= 1'b0;
                        pri_gate_o.low_side_gate[g] <= 1'b1;
                    end else if (reverse_current_block_mode_i &&
                                 pri_cmp_i.zero_cross[g]) begin
                        // Zero at the node: stop before current reverses
                        pri_gate_o.low_side_gate[g] <= 1'b0;
                    end
                end
            end

            // Secondary slice: same architecture, slice 0 only
            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    sec_gate_o.pwm[g] <= 1'b0;
                    sec_gate_o.low_side_gate[g] <= 1'b0;
                    sec_gate_o.phase_clock[g] <= 1'b0;
                end else if (!active || !sec_en[g]) begin
                    sec_gate_o.pwm[g] <= 1'b0;
                    sec_gate_o.low_side_gate[g] <= 1'b0;
                    sec_gate_o.phase_clock[g] <= 1'b0;
                end else begin
                    sec_gate_o.phase_clock[g] <= sec_clk[g];
                    // Same priority as the primary slices: the clock
                    // wins over a window hit in the same cycle
                    if (sec_clk[g]) begin
                        sec_gate_o.pwm[g] <= 1'b1;
                        sec_gate_o.low_side_gate[g] <= 1'b0;
                    end else if (sec_cmp_i.window_hit[g]) begin
                        // End of on-time: the low side takes over
                        sec_gate_o.pwm[g] <= 1'b0;
                        sec_gate_o.low_side_gate[g] <= 1'b1;
                    end else if (reverse_current_block_mode_i &&
                                 sec_cmp_i.zero_cross[g]) begin
                        // Zero at the node: stop before current reverses
                        sec_gate_o.low_side_gate[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// File: sim/mps_cmp_model.sv
/* Comparator model: master events every 11 cycles, window hit 4 cycles
   after each phase clock, primary-rail zero crossing 3 cycles after that. */
`timescale 1ns/10ps
`default_nettype none
module mps_cmp_model (
    // Clock, reset, bench control
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_en_i,
    // Block side
    input wire mps_pkg::mps_gate_s pri_gate_i,
    input wire mps_pkg::mps_gate_s sec_gate_i,
    output var mps_pkg::mps_cmp_s pri_cmp_o,
    output var mps_pkg::mps_cmp_s sec_cmp_o
);
    import mps_pkg::*;
    logic [3:0] cnt_q; // Master ramp period
    logic [11:0] pw_q; // Slave ramp delay lines
    logic [8:0] wz_q; // Low gate conduction delay
    logic [3:0] sw_q; // Secondary slave delay
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 4'h0;
            pw_q <= 12'h000;
            wz_q <= 9'h000;
            sw_q <= 4'h0;
        end else begin
            cnt_q <= (cnt_q == 4'hA || !tick_en_i) ? 4'h0 : cnt_q + 4'h1;
            pw_q <= {pw_q[8:0], pri_gate_i.phase_clock};
            wz_q <= {wz_q[5:0], pw_q[11:9]};
            sw_q <= {sw_q[2:0], sec_gate_i.phase_clock[0]};
        end
    end
    // Secondary events sit mid-period so the rails interleave
    assign pri_cmp_o = '{window_hit: pw_q[11:9], zero_cross: wz_q[8:6],
        master_hit: tick_en_i && cnt_q == 4'hA};
    assign sec_cmp_o = '{window_hit: {2'h0, sw_q[3]}, zero_cross: 3'h0,
        master_hit: tick_en_i && cnt_q == 4'h5};
endmodule
`default_nettype wire

// File: sim/mps_seq_monitor.sv
/* Checker: master pulse, rotation, PWM set/clear, low gate, status.
   Assumes a bind to mps_sequencer. */
`timescale 1ns/10ps
`default_nettype none
module mps_seq_monitor (
    // Clock, reset, inputs
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic por_ok_i,
    input wire logic regulator_on_request_i,
    input wire logic reverse_current_block_mode_i,
    input wire mps_pkg::mps_phases_e phases_i,
    input wire mps_pkg::mps_cmp_s pri_cmp_i,
    // Outputs
    input wire mps_pkg::mps_gate_s pri_gate_o,
    input wire logic [1:0] ramp_reset_o,
    input wire logic power_good_out_o,
    input wire logic alert_n_o
);
    import mps_pkg::*;
    logic on;
    logic [2:0] pc;
    logic [2:0] last_q; // Last phase clock; cleared when idle
    assign on = por_ok_i && regulator_on_request_i;
    assign pc = pri_gate_o.phase_clock;
    // Rotation is only defined from one pulse to the next
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) last_q <= 3'h0;
        else if (!on) last_q <= 3'h0;
        else if (pc != 3'h0) last_q <= pc;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_mclk;
        pri_cmp_i.master_hit && power_good_out_o && on |=>
            ramp_reset_o[0] && $onehot(pc);
    endproperty
    a_mclk: assert property (p_mclk) else $error("no pulse");
    property p_rot3;
        phases_i == MPS_PH3 && pc != 3'h0 && last_q != 3'h0 |->
            pc == {last_q[1:0], last_q[2]};
    endproperty
    a_rot3: assert property (p_rot3) else $error("bad 3 ph");
    property p_rot2;
        phases_i == MPS_PH2 && pc != 3'h0 && last_q != 3'h0 |->
            pc == {1'h0, last_q[0], last_q[1]};
    endproperty
    a_rot2: assert property (p_rot2) else $error("bad 2 ph");
    property p_rot1;
        pc != 3'h0 && (last_q == 3'h0 || phases_i == MPS_PH1) |->
            pc == 3'h1;
    endproperty
    a_rot1: assert property (p_rot1) else $error("bad slot");
    property p_set;
        pc != 3'h0 |-> (pri_gate_o.pwm & pc) == pc;
    endproperty
    a_set: assert property (p_set) else $error("pwm not set");
    property p_clr;
        pri_cmp_i.window_hit != 3'h0 |=>
            (pri_gate_o.pwm & ~pc & $past(pri_cmp_i.window_hit)) == 3'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("pwm stuck");
    property p_rcb;
        reverse_current_block_mode_i && pri_cmp_i.zero_cross != 3'h0 |=>
            (pri_gate_o.low_side_gate & $past(pri_cmp_i.zero_cross)) == 3'h0;
    endproperty
    a_rcb: assert property (p_rcb) else $error("low gate on");
    property p_pg;
        $rose(power_good_out_o) |-> $fell(alert_n_o);
    endproperty
    a_pg: assert property (p_pg) else $error("alert late");
endmodule
bind mps_sequencer mps_seq_monitor mon_u (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .por_ok_i(por_ok_i),
    .regulator_on_request_i(regulator_on_request_i),
    .reverse_current_block_mode_i(reverse_current_block_mode_i),
    .phases_i(phases_i), .pri_cmp_i(pri_cmp_i), .pri_gate_o(pri_gate_o),
    .ramp_reset_o(ramp_reset_o), .power_good_out_o(power_good_out_o),
    .alert_n_o(alert_n_o));
`default_nettype wire

// File: sim/tb_multiphase_pwm_sequencer.sv
/* Bench: start-up, rotation per mode, slice set/clear, POR delay.
   Assumes mps_cmp_model on the comparator side. */
`timescale 1ns/10ps
`default_nettype none
module tb_multiphase_pwm_sequencer;
    import mps_pkg::*;
    logic clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic por = 1'h0;
    logic req = 1'h0;
    logic rcb = 1'h0;
    logic cmd = 1'h0;
    logic tick = 1'h0; // Lets the model fire master events
    logic [7:0] code = 8'h00;
    mps_phases_e phases = MPS_PH3;
    mps_cmp_s pc_i, sc_i;
    mps_gate_s pg_o, sg_o;
    logic [1:0] rr;
    logic [7:0] dac;
    logic pg, al_n;
    int failures = 0;
    int n_checks = 0;
    int cyc_n = 0;
    always #25 clk_i = ~clk_i;
    mps_sequencer dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .por_ok_i(por),
        .regulator_on_request_i(req), .reverse_current_block_mode_i(rcb),
        .phases_i(phases), .set_target_voltage_cmd_i(cmd),
        .target_code_i(code), .pri_cmp_i(pc_i), .sec_cmp_i(sc_i),
        .pri_gate_o(pg_o), .sec_gate_o(sg_o), .ramp_reset_o(rr),
        .dac_code_o(dac), .power_good_out_o(pg), .alert_n_o(al_n));
    mps_cmp_model cmp_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .tick_en_i(tick),
        .pri_gate_i(pg_o), .sec_gate_i(sg_o), .pri_cmp_o(pc_i),
        .sec_cmp_o(sc_i));
    task automatic check(string w, logic [31:0] s, logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            $display("BAD %s exp %h seen %h", w, e, s);
            failures++;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Sample on negedges; a bound keeps a dead design from hanging
    task automatic wait_pg(output int n);
        n = 0;
        while (pg !== 1'h1 && n < 60000) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic t_start();
        int n;
        @(posedge clk_i);
        por <= 1'h1;
        code <= 8'h07;
        cmd <= 1'h1;
        @(posedge clk_i);
        code <= 8'h04; // Later command must win
        @(posedge clk_i);
        cmd <= 1'h0;
        cyc(10);
        check("idle pg", {dac, pg}, 9'h000);
        @(posedge clk_i);
        req <= 1'h1;
        cyc(2 * SS_STEP_CYC + 10);
        check("mid ramp", dac > 8'h00 && dac < 8'h04, 1'h1);
        wait_pg(n);
        check("ramp end", {dac, al_n}, 9'h008);
        $display("start done");
    endtask
    task automatic t_rot(mps_phases_e ph, int n);
        int slot = 0;
        int seen = 0;
        int secs = 0;
        @(posedge clk_i);
        req <= 1'h0;
        cyc(3);
        @(posedge clk_i);
        phases <= ph;
        req <= 1'h1;
        tick <= 1'h1;
        for (int i = 0; i < 200 && seen < 6; i++) begin
            cyc(1);
            if (sg_o.phase_clock[0] === 1'h1) begin
                secs++;
                check("sec one", sg_o.phase_clock, 3'h1);
                check("sec set", {sg_o.pwm[0], rr[1]}, 2'h3);
            end
            if (pg_o.phase_clock !== 3'h0) begin
                check("clk", pg_o.phase_clock, 3'h1 << slot);
                check("ramp rst", rr[0], 1'h1);
                check("pwm set", pg_o.pwm[slot], 1'h1);
                slot = (slot + 1) % n;
                seen++;
            end
        end
        check("pulses", seen, 6);
        check("sec clk", secs > 0, 1'h1);
        @(posedge clk_i);
        tick <= 1'h0;
        $display("rotation %0d done", n);
    endtask
    task automatic t_slice(logic mode);
        int i = 0;
        @(posedge clk_i);
        rcb <= mode;
        tick <= 1'h1;
        while (pg_o.phase_clock[0] !== 1'h1 && i < 100) begin
            cyc(1);
            i++;
        end
        @(posedge clk_i);
        tick <= 1'h0;
        cyc(5);
        check("pwm clr", {pg_o.pwm[0], pg_o.low_side_gate[0]}, 2'h1);
        cyc(4);
        check("low gate", pg_o.low_side_gate[0], !mode);
        $display("slice %0d done", mode);
    endtask
    task automatic t_por();
        int n;
        @(posedge clk_i);
        por <= 1'h0;
        cyc(3);
        check("off pg", pg, 1'h0);
        check("off gate", {pg_o, sg_o}, 18'h0_0000);
        @(posedge clk_i);
        por <= 1'h1;
        wait_pg(n);
        check("por min", n >= POR_DELAY_CYC, 1'h1);
        check("por max", n < POR_DELAY_CYC + 300, 1'h1);
        @(posedge clk_i);
        code <= 8'h09;
        cmd <= 1'h1;
        @(posedge clk_i);
        cmd <= 1'h0;
        cyc(3);
        check("run cmd", {dac, pg}, 9'h013);
        $display("por done");
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 70000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'h1;
        cyc(3);
        check("rst", {pg_o, sg_o, rr, pg, al_n}, 16'h0001);
        t_start();
        t_rot(MPS_PH2, 2);
        t_rot(MPS_PH1, 1);
        t_rot(MPS_PH3, 3);
        t_slice(1'h0);
        t_slice(1'h1);
        t_por();
        finish_test();
    end
endmodule
`default_nettype wire
